// ### rtl/core_interrupt_sources.v
/*
  Core interrupt source logic: two edge-triggered pin sources, the
  timer0 overflow source and the peripheral summary source, with their
  flag, enable and polarity bits in special registers, bank decode for
  the peripheral registers, vector selection and sleep wake.
  Flags are sticky: each event sets its flag whatever its enable, and
  only a software write of zero clears it; a set in the clearing cycle
  wins. The request, vector, wake and bank outputs are registered, so
  they follow the flags one cycle late.
  Assumes a single-cycle special register port driven by the core,
  pins and the timer0 count synchronous to clk_i, and peripherals that
  pulse their request lines for one cycle per event.
  Assumes the core sequencer raises sleeping_i while it sleeps and
  drops it again once it has seen wake_o.
*/
`timescale 1ns/1ps
`default_nettype none
`include "core_interrupt_sources_consts.vh"

module core_interrupt_sources #(
  // bus and datapath widths
  parameter DATA_WIDTH = 8,
  parameter ADDR_WIDTH = 8,
  parameter TIMER_WIDTH = 16,
  parameter VECTOR_WIDTH = 16,
  // peripherals allowed to end sleep, one bit each
  parameter [7:0] PERIPHERAL_WAKE_MASK = 8'hFF
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // special register port from the core
  input wire [ADDR_WIDTH-1:0] sfr_addr_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  input wire [DATA_WIDTH-1:0] sfr_wdata_i,
  output reg [DATA_WIDTH-1:0] sfr_rdata_o,
  output reg sfr_rvalid_o,
  // external pins
  input wire external_interrupt_pin_i,
  input wire external_clock_pin_i,
  // timer0 count and peripheral request pulses
  input wire [TIMER_WIDTH-1:0] timer0_count_i,
  input wire [DATA_WIDTH-1:0] peripheral_set_i,
  // core sequencer
  input wire sleeping_i,
  output reg irq_request_o,
  output reg [VECTOR_WIDTH-1:0] vector_o,
  output reg wake_o,
  output reg [3:0] bank_o
);

  // reset image of the status register; its bits are loaded one by one
  localparam [7:0] RST_STATUS = `RST_INTERRUPT_STATUS;

  // register state
  reg [DATA_WIDTH-1:0] timer0_status_control;
  reg [DATA_WIDTH-1:0] bank_selector;
  // sticky event flags
  reg pin_interrupt_flag;
  reg timer0_overflow_flag;
  reg clock_pin_flag;
  // enables gate requests only
  reg pin_interrupt_enable;
  reg timer0_overflow_enable;
  reg clock_pin_enable;
  reg peripheral_summary_enable;
  // peripheral flags and their enables, bank one
  reg [DATA_WIDTH-1:0] peripheral_request_flags;
  reg [DATA_WIDTH-1:0] peripheral_enable_mask;
  // timer0 history for the rollover compare
  reg [TIMER_WIDTH-1:0] timer0_prev;
  reg timer0_prev_valid;

  // decoded accesses and events
  wire [1:0] edge_pulse;
  wire [1:0] edge_polarity;
  wire pin_edge;
  wire clock_pin_edge;
  wire timer0_rollover;
  // address decode results
  wire in_banked_window;
  wire peripheral_bank;
  wire hit_timer0_status_control;
  wire hit_interrupt_status;
  wire hit_bank_selector;
  wire hit_peripheral_request_flags;
  wire hit_peripheral_enable_mask;
  wire hit_any;
  wire peripheral_summary_flag;
  wire [DATA_WIDTH-1:0] interrupt_status;
  // per-source requests and wake terms
  wire pin_request;
  wire timer0_request;
  wire clock_pin_request;
  wire peripheral_request;
  wire peripheral_wake;
  wire request_any;
  wire wake_any;
  // combinational next values
  reg [VECTOR_WIDTH-1:0] next_vector;
  reg [DATA_WIDTH-1:0] next_rdata;

  // polarity bits for the two pin detectors, index 0 is the pin source
  // a polarity change alone makes no edge, the detectors compare levels
  assign edge_polarity[0] = timer0_status_control[`BIT_PIN_EDGE_POLARITY];
  assign edge_polarity[1] = timer0_status_control[`BIT_CLOCK_PIN_EDGE_POLARITY];

  // one detector per external pin
  // each adds a cycle, so a pin change shows in its flag two edges later
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
      pin_edge_detect u_edge (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(gi == 0 ? external_interrupt_pin_i : external_clock_pin_i),
        .rising_sel_i(edge_polarity[gi]),
        .edge_o(edge_pulse[gi])
      );
    end
  endgenerate

  assign pin_edge = edge_pulse[0];
  assign clock_pin_edge = edge_pulse[1];

  // rollover seen as max followed directly by zero
  // a jump from FFFFh to any other value is no rollover;
  // the valid bit keeps the reset history from faking one
  assign timer0_rollover = timer0_prev_valid &&
    (timer0_prev == `TIMER0_COUNT_MAX) &&
    (timer0_count_i == `TIMER0_COUNT_ZERO);

  // only 10h..17h look at the bank; every other address is unbanked
  // all eight selector bits are stored, only the low nibble picks the bank
  assign in_banked_window = (sfr_addr_i >= `BANKED_LOW) && (sfr_addr_i <= `BANKED_HIGH);
  assign peripheral_bank = (bank_selector[3:0] == `BANK_PERIPHERAL);

  // address decode
  assign hit_timer0_status_control = (sfr_addr_i == `ADDR_TIMER0_STATUS_CONTROL);
  assign hit_interrupt_status = (sfr_addr_i == `ADDR_INTERRUPT_STATUS);
  assign hit_bank_selector = (sfr_addr_i == `ADDR_BANK_SELECTOR);
  assign hit_peripheral_request_flags = in_banked_window && peripheral_bank &&
    (sfr_addr_i == `ADDR_PERIPHERAL_REQUEST_FLAGS);
  assign hit_peripheral_enable_mask = in_banked_window && peripheral_bank &&
    (sfr_addr_i == `ADDR_PERIPHERAL_ENABLE_MASK);
  // any register of this block, for the read valid
  assign hit_any = hit_timer0_status_control | hit_interrupt_status |
    hit_bank_selector | hit_peripheral_request_flags | hit_peripheral_enable_mask;

  // summary flag is live, never stored, so it cannot go stale
  assign peripheral_summary_flag = |(peripheral_request_flags & peripheral_enable_mask);

  // status register image as software sees it
  // bit 7 is computed live, the other seven are stored flops
  assign interrupt_status = {
    peripheral_summary_flag,
    clock_pin_flag,
    timer0_overflow_flag,
    pin_interrupt_flag,
    peripheral_summary_enable,
    clock_pin_enable,
    timer0_overflow_enable,
    pin_interrupt_enable
  };

  // enables only gate requests, flags stay independent of them
  assign pin_request = pin_interrupt_flag & pin_interrupt_enable;
  assign timer0_request = timer0_overflow_flag & timer0_overflow_enable;
  assign clock_pin_request = clock_pin_flag & clock_pin_enable;
  assign peripheral_request = peripheral_summary_flag & peripheral_summary_enable;

  // only peripherals in the wake mask may end sleep
  assign peripheral_wake = peripheral_summary_enable &
    (|(peripheral_request_flags & peripheral_enable_mask & PERIPHERAL_WAKE_MASK));

  // any enabled source asks the sequencer for service
  assign request_any = pin_request | timer0_request | clock_pin_request | peripheral_request;

  // timer0 halts in sleep, so its overflow is left out of the wake term
  assign wake_any = pin_request | clock_pin_request | peripheral_wake;

  // timer0 history for the rollover compare
  // one stored count is enough, rollover needs only the last value
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      timer0_prev <= `TIMER0_COUNT_ZERO;
      timer0_prev_valid <= 1'b0;
    end else begin
      timer0_prev <= timer0_count_i;
      timer0_prev_valid <= 1'b1;
    end
  end

  // timer0 status/control and bank selector, plain storage
  // control bits 5..0 are kept for software but drive nothing here
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      timer0_status_control <= `RST_TIMER0_STATUS_CONTROL;
      bank_selector <= `RST_BANK_SELECTOR;
    end else begin
      if (sfr_wr_i && hit_timer0_status_control) begin
        timer0_status_control <= sfr_wdata_i;
      end
      if (sfr_wr_i && hit_bank_selector) begin
        bank_selector <= sfr_wdata_i;
      end
    end
  end

  // interrupt status: enables are plain, flags take set over clear
  // a written one sets a flag, which lets software raise a request
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_interrupt_enable <= RST_STATUS[`BIT_PIN_INTERRUPT_ENABLE];
      timer0_overflow_enable <= RST_STATUS[`BIT_TIMER0_OVERFLOW_ENABLE];
      clock_pin_enable <= RST_STATUS[`BIT_CLOCK_PIN_ENABLE];
      peripheral_summary_enable <= RST_STATUS[`BIT_PERIPHERAL_SUMMARY_ENABLE];
      pin_interrupt_flag <= RST_STATUS[`BIT_PIN_INTERRUPT_FLAG];
      timer0_overflow_flag <= RST_STATUS[`BIT_TIMER0_OVERFLOW_FLAG];
      clock_pin_flag <= RST_STATUS[`BIT_CLOCK_PIN_FLAG];
    end else if (sfr_wr_i && hit_interrupt_status) begin
      // summary bit is read-only, a write to bit 7 is dropped
      pin_interrupt_enable <= sfr_wdata_i[`BIT_PIN_INTERRUPT_ENABLE];
      timer0_overflow_enable <= sfr_wdata_i[`BIT_TIMER0_OVERFLOW_ENABLE];
      clock_pin_enable <= sfr_wdata_i[`BIT_CLOCK_PIN_ENABLE];
      peripheral_summary_enable <= sfr_wdata_i[`BIT_PERIPHERAL_SUMMARY_ENABLE];
      // an edge in the clearing cycle still lands
      pin_interrupt_flag <= sfr_wdata_i[`BIT_PIN_INTERRUPT_FLAG] | pin_edge;
      timer0_overflow_flag <= sfr_wdata_i[`BIT_TIMER0_OVERFLOW_FLAG] | timer0_rollover;
      clock_pin_flag <= sfr_wdata_i[`BIT_CLOCK_PIN_FLAG] | clock_pin_edge;
    end else begin
      // no write: flags only accumulate events
      pin_interrupt_flag <= pin_interrupt_flag | pin_edge;
      timer0_overflow_flag <= timer0_overflow_flag | timer0_rollover;
      clock_pin_flag <= clock_pin_flag | clock_pin_edge;
    end
  end

  // peripheral flags: software writes, peripheral pulses win
  // a pulse in the write cycle is or-ed in, so no event is lost
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      peripheral_request_flags <= `RST_PERIPHERAL_REQUEST_FLAGS;
    end else if (sfr_wr_i && hit_peripheral_request_flags) begin
      peripheral_request_flags <= sfr_wdata_i | peripheral_set_i;
    end else begin
      peripheral_request_flags <= peripheral_request_flags | peripheral_set_i;
    end
  end

  // peripheral enable mask, plain storage
  // only bank one reaches it, through the hit decode above
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      peripheral_enable_mask <= `RST_PERIPHERAL_ENABLE_MASK;
    end else if (sfr_wr_i && hit_peripheral_enable_mask) begin
      peripheral_enable_mask <= sfr_wdata_i;
    end
  end

  // fixed priority: lowest vector wins, idle shows the reset vector
  // vectoring clears nothing; the handler must clear its own flag
  always @* begin
    next_vector = `VEC_RESET;
    if (pin_request) begin
      next_vector = `VEC_PIN_INTERRUPT;
    end else if (timer0_request) begin
      next_vector = `VEC_TIMER0_OVERFLOW;
    end else if (clock_pin_request) begin
      next_vector = `VEC_CLOCK_PIN;
    end else if (peripheral_request) begin
      next_vector = `VEC_PERIPHERAL;
    end
  end

  // read mux, unmapped addresses read zero and give no valid
  // the window never overlaps the unbanked registers, so order is free
  always @* begin
    next_rdata = {DATA_WIDTH{1'b0}};
    if (hit_timer0_status_control) begin
      next_rdata = timer0_status_control;
    end else if (hit_interrupt_status) begin
      next_rdata = interrupt_status;
    end else if (hit_bank_selector) begin
      next_rdata = bank_selector;
    end else if (hit_peripheral_request_flags) begin
      next_rdata = peripheral_request_flags;
    end else if (hit_peripheral_enable_mask) begin
      next_rdata = peripheral_enable_mask;
    end
  end

  // registered read answer, one cycle after the strobe
  // data hold between reads so the core may pick them up late
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      sfr_rdata_o <= {DATA_WIDTH{1'b0}};
      sfr_rvalid_o <= 1'b0;
    end else begin
      sfr_rvalid_o <= sfr_rd_i & hit_any;
      if (sfr_rd_i) begin
        sfr_rdata_o <= next_rdata;
      end
    end
  end

  // requests to the sequencer, all registered
  // bank_o lets the core see the bank without a read, one cycle late
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      // reset vector shows while reset holds
      irq_request_o <= 1'b0;
      vector_o <= `VEC_RESET;
      wake_o <= 1'b0;
      bank_o <= 4'h0;
    end else begin
      irq_request_o <= request_any;
      vector_o <= next_vector;
      wake_o <= sleeping_i & wake_any;
      bank_o <= bank_selector[3:0];
    end
  end

endmodule // core_interrupt_sources

`default_nettype wire

// ### rtl/core_interrupt_sources_consts.vh
/*
  Constants for the core interrupt source logic: special register
  addresses, bank decode limits, bit positions, reset values and the
  fixed program-memory vectors.
  Assumes it is included by bare name from files under rtl/.
*/
`ifndef CORE_INTERRUPT_SOURCES_CONSTS_VH
`define CORE_INTERRUPT_SOURCES_CONSTS_VH

// special register addresses
`define ADDR_TIMER0_STATUS_CONTROL 8'h05
`define ADDR_INTERRUPT_STATUS 8'h07
`define ADDR_BANK_SELECTOR 8'h0F
`define ADDR_PERIPHERAL_REQUEST_FLAGS 8'h16
`define ADDR_PERIPHERAL_ENABLE_MASK 8'h17

// banked window and the bank holding the peripheral registers
`define BANKED_LOW 8'h10
`define BANKED_HIGH 8'h17
`define BANK_PERIPHERAL 4'h1

// timer0 status/control bit positions
`define BIT_PIN_EDGE_POLARITY 7
`define BIT_CLOCK_PIN_EDGE_POLARITY 6

// interrupt status bit positions
`define BIT_PERIPHERAL_SUMMARY_FLAG 7
`define BIT_CLOCK_PIN_FLAG 6
`define BIT_TIMER0_OVERFLOW_FLAG 5
`define BIT_PIN_INTERRUPT_FLAG 4
`define BIT_PERIPHERAL_SUMMARY_ENABLE 3
`define BIT_CLOCK_PIN_ENABLE 2
`define BIT_TIMER0_OVERFLOW_ENABLE 1
`define BIT_PIN_INTERRUPT_ENABLE 0

// reset values
`define RST_TIMER0_STATUS_CONTROL 8'h00
`define RST_INTERRUPT_STATUS 8'h00
`define RST_PERIPHERAL_REQUEST_FLAGS 8'h02
`define RST_PERIPHERAL_ENABLE_MASK 8'h00
`define RST_BANK_SELECTOR 8'h00

// timer0 rollover points
`define TIMER0_COUNT_MAX 16'hFFFF
`define TIMER0_COUNT_ZERO 16'h0000

// program-memory vectors
`define VEC_RESET 16'h0000
`define VEC_PIN_INTERRUPT 16'h0008
`define VEC_TIMER0_OVERFLOW 16'h0010
`define VEC_CLOCK_PIN 16'h0018
`define VEC_PERIPHERAL 16'h0020

`endif

// ### rtl/pin_edge_detect.v
/*
  Edge detector for one external pin with selectable polarity.
  Assumes the pin is already synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_edge_detect (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // pin and polarity select
  input wire pin_i,
  input wire rising_sel_i,
  // one-cycle pulse on a valid edge
  output reg edge_o
);

  reg prev;
  reg armed;

  // first cycle after reset only samples, so a pin held high is no edge
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev <= 1'b0;
      armed <= 1'b0;
      edge_o <= 1'b0;
    end else begin
      prev <= pin_i;
      armed <= 1'b1;
      if (rising_sel_i) begin
        edge_o <= armed & ~prev & pin_i;
      end else begin
        edge_o <= armed & prev & ~pin_i;
      end
    end
  end

endmodule // pin_edge_detect

`default_nettype wire

// ### sim/core_irq_sva.sv
/* checker for the core interrupt source block, port timing only.
   assumes binding onto core_interrupt_sources with default widths. */
`timescale 1ns/1ps
`default_nettype none
module core_irq_sva (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic sfr_rvalid_o,
  // sequencer side
  input wire logic sleeping_i,
  input wire logic irq_request_o,
  input wire logic [15:0] vector_o,
  input wire logic wake_o,
  input wire logic [3:0] bank_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // vector and request relations
  reset_vec_a: assert property (
    $rose(rst_n_i) |-> vector_o == 16'h0000) else $error("vector not zero after reset");
  idle_vec_a: assert property (
    !irq_request_o |-> vector_o == 16'h0000) else $error("vector set with no request");
  req_vec_a: assert property (
    irq_request_o |-> vector_o inside {16'h0008, 16'h0010, 16'h0018, 16'h0020})
    else $error("request with unknown vector");
  wake_sleep_a: assert property (
    wake_o |-> $past(sleeping_i)) else $error("wake while awake");
  wake_req_a: assert property (
    wake_o |-> irq_request_o) else $error("wake with no request");
  clear_fall_a: assert property (
    $fell(irq_request_o) && $past(rst_n_i) |-> $past(sfr_wr_i) || $past(sfr_wr_i, 2))
    else $error("request dropped with no write");
  // register port relations; a bank write just before is excluded as bank_o lags
  unbank_rd_a: assert property (
    sfr_rd_i && sfr_addr_i inside {8'h05, 8'h07} |=> sfr_rvalid_o)
    else $error("unbanked read not answered");
  bank_miss_a: assert property (
    sfr_rd_i && sfr_addr_i == 8'h16 && bank_o != 4'h1 && !$past(sfr_wr_i)
    |=> !sfr_rvalid_o && sfr_rdata_o == 8'h00) else $error("bank miss answered");
  rvalid_src_a: assert property (
    sfr_rvalid_o |-> $past(sfr_rd_i)) else $error("read valid with no read");
  rd_hold_a: assert property (
    !$past(sfr_rd_i) && $past(rst_n_i) |-> $stable(sfr_rdata_o))
    else $error("read data moved with no read");
  // main scenarios reached
  pin_cov: cover property (irq_request_o && vector_o == 16'h0008);
  perif_cov: cover property (irq_request_o && vector_o == 16'h0020);
  wake_cov: cover property (wake_o);
endmodule // core_irq_sva
bind core_interrupt_sources core_irq_sva i_sva (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
  .sfr_rdata_o(sfr_rdata_o), .sfr_rvalid_o(sfr_rvalid_o), .sleeping_i(sleeping_i),
  .irq_request_o(irq_request_o), .vector_o(vector_o), .wake_o(wake_o), .bank_o(bank_o));
`default_nettype wire

// ### sim/core_seq_model.sv
/* model of the core sequencer: sleeps on command, leaves sleep on wake.
   assumes wake_i is the block's registered wake level. */
`timescale 1ns/1ps
`default_nettype none
module core_seq_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // sleep command and wake
  input wire logic sleep_cmd_i,
  input wire logic wake_i,
  output logic sleeping_o
);
  // sleep holds until woken; a pending wake blocks sleeping at all
  always @(posedge clk_i) begin
    if (!rst_n_i || wake_i) begin
      sleeping_o <= 1'b0;
    end else if (sleep_cmd_i) begin
      sleeping_o <= 1'b1;
    end
  end
endmodule // core_seq_model
`default_nettype wire

// ### sim/tb.sv
/* self-checking bench for the core interrupt source block.
   assumes the block's single-cycle register port and the sequencer model. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i, rst_n_i, sfr_wr_i, sfr_rd_i, sleep_cmd, sleeping_i, wake_o;
  logic external_interrupt_pin_i, external_clock_pin_i, irq_request_o, v;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, peripheral_set_i, d;
  logic [15:0] timer0_count_i, vector_o;
  logic [3:0] rows [8];
  logic [3:0] r;
  int num_errors = 0;
  int n_tests = 0;
  logic v_o;
  logic [3:0] bank_o;
  core_interrupt_sources i_core_interrupt_sources (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .sfr_rvalid_o(v_o),
    .external_interrupt_pin_i(external_interrupt_pin_i),
    .external_clock_pin_i(external_clock_pin_i), .timer0_count_i(timer0_count_i),
    .peripheral_set_i(peripheral_set_i), .sleeping_i(sleeping_i),
    .irq_request_o(irq_request_o), .vector_o(vector_o), .wake_o(wake_o), .bank_o(bank_o));
  core_seq_model i_core_seq_model (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .sleep_cmd_i(sleep_cmd), .wake_i(wake_o), .sleeping_o(sleeping_i));
  // core clock, 5 ns period
  always #2.5 clk_i = ~clk_i;
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one-cycle strobes, released one edge before the next request
  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    @(posedge clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= dat;
    sfr_wr_i <= 1'b1;
    @(posedge clk_i);
    sfr_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge clk_i);
    sfr_rd_i <= 1'b0;
    #1;
    d = sfr_rdata_o;
    v = v_o;
  endtask
  task automatic pin(input logic sel, input logic lvl);
    @(posedge clk_i);
    if (sel) external_clock_pin_i <= lvl;
    else external_interrupt_pin_i <= lvl;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic do_reset(input int n);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (n) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk("reset vector", vector_o, 16'h0000);
    rd(8'h05);
    chk("control reset", d, 8'h00);
    rd(8'h07);
    chk("status reset", {v, d}, 9'h100);
  endtask
  task automatic final_report();
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    final_report();
  end
  // main sequence
  initial begin
    {clk_i, rst_n_i, sfr_wr_i, sfr_rd_i, sleep_cmd} = 5'h00;
    {external_interrupt_pin_i, external_clock_pin_i} = 2'h0;
    {sfr_addr_i, sfr_wdata_i, peripheral_set_i, timer0_count_i} = 32'h0000_0000;
    // row: clock pin, polarity, new level, flag expected
    rows = '{4'h7, 4'h4, 4'h1, 4'h2, 4'hF, 4'hC, 4'h9, 4'hA};
    // reset is already low; five more edges make six in all
    do_reset(5);
    for (int i = 0; i < 8; i++) begin
      r = rows[i];
      wr(8'h05, {r[2], r[2], 6'h00});
      pin(r[3], !r[1]);
      wr(8'h07, r[3] ? 8'h04 : 8'h01);
      pin(r[3], r[1]);
      rd(8'h07);
      chk("edge flag", d[r[3] ? 6 : 4], r[0]);
      chk("request", irq_request_o, r[0]);
      chk("vector", vector_o, r[0] ? (r[3] ? 16'h0018 : 16'h0008) : 16'h0000);
    end
    // rollover while disabled still flags, then enable raises request
    wr(8'h07, 8'h00);
    @(posedge clk_i) timer0_count_i <= 16'hFFFF;
    @(posedge clk_i) timer0_count_i <= 16'h0000;
    rd(8'h07);
    chk("rollover flag", d, 8'h20);
    chk("disabled request", irq_request_o, 1'b0);
    wr(8'h07, 8'h22);
    repeat (3) @(posedge clk_i);
    chk("timer vector", vector_o, 16'h0010);
    // banked peripheral registers and the summary flag
    wr(8'h07, 8'h00);
    rd(8'h16);
    chk("bank 0 miss", {v, d}, 9'h000);
    wr(8'h0F, 8'h01);
    rd(8'h16);
    chk("flags reset", {v, d}, 9'h102);
    chk("bank copy", bank_o, 4'h1);
    @(posedge clk_i) peripheral_set_i <= 8'h01;
    @(posedge clk_i) peripheral_set_i <= 8'h00;
    rd(8'h16);
    chk("flag set", d, 8'h03);
    wr(8'h17, 8'h01);
    wr(8'h07, 8'h88);
    rd(8'h07);
    chk("summary on", d, 8'h88);
    chk("summary vector", vector_o, 16'h0020);
    wr(8'h17, 8'h00);
    rd(8'h07);
    chk("summary off", d, 8'h08);
    // pin outranks a pending summary
    wr(8'h17, 8'h01);
    wr(8'h05, 8'h80);
    pin(1'b0, 1'b0);
    wr(8'h07, 8'h09);
    pin(1'b0, 1'b1);
    chk("priority vector", vector_o, 16'h0008);
    // enabled pin edge wakes the sleeping core
    wr(8'h07, 8'h01);
    pin(1'b0, 1'b0);
    @(posedge clk_i) sleep_cmd <= 1'b1;
    @(posedge clk_i) sleep_cmd <= 1'b0;
    #1;
    chk("asleep", sleeping_i, 1'b1);
    pin(1'b0, 1'b1);
    #1;
    chk("woken", sleeping_i, 1'b0);
    // enabled clock pin edge wakes as well, falling since bit 6 is zero
    wr(8'h07, 8'h04);
    @(posedge clk_i) sleep_cmd <= 1'b1;
    @(posedge clk_i) sleep_cmd <= 1'b0;
    #1;
    chk("asleep clock", sleeping_i, 1'b1);
    pin(1'b1, 1'b0);
    #1;
    chk("clock woken", sleeping_i, 1'b0);
    // enabled peripheral flag wakes too
    wr(8'h16, 8'h00);
    wr(8'h07, 8'h08);
    @(posedge clk_i) sleep_cmd <= 1'b1;
    @(posedge clk_i) sleep_cmd <= 1'b0;
    #1;
    chk("asleep peripheral", sleeping_i, 1'b1);
    @(posedge clk_i) peripheral_set_i <= 8'h01;
    @(posedge clk_i) peripheral_set_i <= 8'h00;
    repeat (3) @(posedge clk_i);
    #1;
    chk("peripheral woken", sleeping_i, 1'b0);
    do_reset(2);
    final_report();
  end
endmodule // tb
`default_nettype wire
